// [irqoc_pkg.sv]
package irqoc_pkg;

  // ---------------------------------------------------------------------------
  // register map, byte addresses on the host register port
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  ADDR_IDENT       = 8'h50;
  localparam logic [7:0]  ADDR_CFG         = 8'h54;
  localparam logic [7:0]  ADDR_FLAGS       = 8'h58;
  localparam logic [7:0]  ADDR_MASK        = 8'h5C;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int          CFG_INTERVAL_LSB = 24;
  localparam int          CFG_RESTART_BIT  = 14;
  localparam int          CFG_ACTIVE_BIT   = 13;
  localparam int          CFG_COMBINED_BIT = 12;
  localparam int          CFG_PIN_EN_BIT   = 8;
  localparam int          CFG_POL_BIT      = 4;
  localparam int          CFG_DRV_BIT      = 0;
  localparam int          IDENT_DESIGN_LSB = 16;
  localparam int          WAKE_BIT         = 17;

  // implemented source bits; reserved bits read as zero
  localparam logic [31:0] SRC_IMPL_MASK    = 32'h83BFE7FF;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] FLAGS_RESET      = 32'h00000000;
  localparam logic [31:0] MASK_RESET       = 32'h00000000;
  localparam logic [7:0]  INTERVAL_RESET   = 8'h00;
  localparam logic        PIN_EN_RESET     = 1'b0;
  localparam logic        POL_RESET        = 1'b0;
  localparam logic        DRV_RESET        = 1'b0;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int          HOLDOFF_UNIT_NS  = 10000;
  localparam int          CLK_PERIOD_NS    = 8;
  localparam int          TICK_CYCLES      = (HOLDOFF_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TICK_W           = 11;
  localparam logic [10:0] TICK_LAST        = 11'(TICK_CYCLES - 1);
  localparam int          CYC_W            = 19;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } irqoc_req_s;

  typedef struct packed {
    logic [7:0]  interval;
    logic        pin_en;
    logic        pol;
    logic        drv;
  } irqoc_cfg_s;

  typedef enum logic [1:0] {
    HO_IDLE = 2'b01,
    HO_HOLD = 2'b10
  } irqoc_hold_e;

endpackage

// [irqoc_tick.sv]
`timescale 1ns/1ns
module irqoc_tick (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clr,
  output logic      tick
);

  logic [irqoc_pkg::TICK_W-1:0] cnt_q;
  logic [irqoc_pkg::TICK_W-1:0] cnt_d;

  // realigned on clr so an interval is a whole number of ticks
  always_comb begin
    if (clr || cnt_q == irqoc_pkg::TICK_LAST) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 11'h001;
    end
    tick = (cnt_q == irqoc_pkg::TICK_LAST) && !clr;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // irqoc_tick

// [irqoc_holdoff.sv]
`timescale 1ns/1ns
module irqoc_holdoff (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       soft_rst,
  input  wire logic       tick,
  input  wire logic       begin_hold,
  input  wire logic [7:0] interval,
  output logic            active
);

  irqoc_pkg::irqoc_hold_e state_q;
  irqoc_pkg::irqoc_hold_e state_d;
  logic [7:0]             count_q;
  logic [7:0]             count_d;
  logic [7:0]             limit_q;
  logic [7:0]             limit_d;
  logic                   cancel;

  assign cancel = (interval == 8'h00);
  assign active = (state_q == irqoc_pkg::HO_HOLD);

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    limit_d = limit_q;
    case (state_q)
      irqoc_pkg::HO_IDLE: begin
        if (begin_hold && !cancel) begin
          state_d = irqoc_pkg::HO_HOLD;
          count_d = 8'h00;
          limit_d = interval;
        end
      end
      irqoc_pkg::HO_HOLD: begin
        if (cancel) begin
          state_d = irqoc_pkg::HO_IDLE;
          count_d = 8'h00;
        end else if (begin_hold) begin
          count_d = 8'h00;
          limit_d = interval;
        end else if (tick) begin
          count_d = count_q + 8'h01;
          if (count_q + 8'h01 == limit_q) begin
            state_d = irqoc_pkg::HO_IDLE;
            count_d = 8'h00;
          end
        end
      end
      default: begin
        state_d = irqoc_pkg::HO_IDLE;
        count_d = 8'h00;
      end
    endcase
    if (soft_rst) begin
      state_d = irqoc_pkg::HO_IDLE;
      count_d = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= irqoc_pkg::HO_IDLE;
      count_q <= 8'h00;
      limit_q <= 8'h00;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      limit_q <= limit_d;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  logic [irqoc_pkg::CYC_W-1:0] cyc_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cyc_q <= '0;
    end else if (begin_hold) begin
      cyc_q <= 19'h00001;
    end else if (active) begin
      cyc_q <= cyc_q + 19'h00001;
    end
  end

  chk_interval_length: assert property (@(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $fell(active) && !$past(cancel) && !$past(begin_hold) && !$past(soft_rst)
      |-> int'($past(cyc_q)) == int'($past(limit_q)) * irqoc_pkg::TICK_CYCLES)
    else $error("holdoff interval length wrong");

endmodule // irqoc_holdoff

// [irqoc_top.sv]
`timescale 1ns/1ns
// Operation
// - hold-off interval sits in config bits 31:24, units of 10 us
// - interval zero disables hold-off, clears counter, delivers pending requests
// - a new non-zero interval governs every later hold-off
// - wake event request is never held off
// - writing one to bit 14 restarts the interval; bit reads zero
// - bit 13 shows hold-off running; requests withheld from pin meanwhile
// - bit 12 shows combined request line, ignoring pin enable and hold-off
// - pin enable bit 8 clear keeps pin deasserted; flags unaffected
// - polarity bit 4: zero active low, one active high
// - driver bit 0: zero open-drain, one push-pull
// - open-drain mode ignores polarity, always active low
// - identity register: design code high half, revision low half
// - polarity and driver bits survive soft reset, cleared by system reset
// - writing one to a flag clears it, zero leaves it
module irqoc_top #(
  parameter logic [15:0] DESIGN_CODE = 16'h1D5A,  // arbitrary value
  parameter logic [15:0] REVISION    = 16'h0003   // arbitrary value
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  soft_rst,
  input  wire irqoc_pkg::irqoc_req_s req,
  output logic [31:0]                rdata,
  input  wire logic [31:0]           src_event,
  output logic                       irq_pin_out,
  output logic                       irq_pin_oe
);

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input irqoc_pkg::irqoc_req_s r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction

  logic wr_cfg;
  logic wr_flags;
  logic wr_mask;
  logic restart;

  assign wr_cfg   = req.wr && hit(req, irqoc_pkg::ADDR_CFG);
  assign wr_flags = req.wr && hit(req, irqoc_pkg::ADDR_FLAGS);
  assign wr_mask  = req.wr && hit(req, irqoc_pkg::ADDR_MASK);
  assign restart  = wr_cfg && req.wdata[irqoc_pkg::CFG_RESTART_BIT];

  // ---------------------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------------------
  irqoc_pkg::irqoc_cfg_s cfg_q;
  irqoc_pkg::irqoc_cfg_s cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (wr_cfg) begin
      cfg_d.interval = req.wdata[irqoc_pkg::CFG_INTERVAL_LSB +: 8];
      cfg_d.pin_en   = req.wdata[irqoc_pkg::CFG_PIN_EN_BIT];
      cfg_d.pol      = req.wdata[irqoc_pkg::CFG_POL_BIT];
      cfg_d.drv      = req.wdata[irqoc_pkg::CFG_DRV_BIT];
    end
    // polarity and driver style are left alone by soft reset
    if (soft_rst) begin
      cfg_d.interval = irqoc_pkg::INTERVAL_RESET;
      cfg_d.pin_en   = irqoc_pkg::PIN_EN_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_q.interval <= irqoc_pkg::INTERVAL_RESET;
      cfg_q.pin_en   <= irqoc_pkg::PIN_EN_RESET;
      cfg_q.pol      <= irqoc_pkg::POL_RESET;
      cfg_q.drv      <= irqoc_pkg::DRV_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ---------------------------------------------------------------------------
  // source flags and mask
  // ---------------------------------------------------------------------------
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] clr_bits;

  always_comb begin
    clr_bits = wr_flags ? req.wdata : 32'h00000000;
    // a new event in the clearing cycle survives
    flags_d  = ((flags_q & ~clr_bits) | src_event) & irqoc_pkg::SRC_IMPL_MASK;
    mask_d   = wr_mask ? (req.wdata & irqoc_pkg::SRC_IMPL_MASK) : mask_q;
    if (soft_rst) begin
      flags_d = irqoc_pkg::FLAGS_RESET;
      mask_d  = irqoc_pkg::MASK_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags_q <= irqoc_pkg::FLAGS_RESET;
      mask_q  <= irqoc_pkg::MASK_RESET;
    end else begin
      flags_q <= flags_d;
      mask_q  <= mask_d;
    end
  end

  // ---------------------------------------------------------------------------
  // request combining and hold-off
  // ---------------------------------------------------------------------------
  logic [31:0] pending;
  logic        combined;
  logic        wake_req;
  logic        other_req;
  logic        active;
  logic        tick;
  logic        irq_on_q;
  logic        irq_on_d;
  logic        begin_hold;

  assign pending   = flags_q & mask_q;
  assign combined  = |pending;
  assign wake_req  = pending[irqoc_pkg::WAKE_BIT];
  assign other_req = |(pending & ~(32'h00000001 << irqoc_pkg::WAKE_BIT));

  always_comb begin
    // wake path bypasses the hold-off gate
    irq_on_d = cfg_q.pin_en && (wake_req || (other_req && !active));
    if (soft_rst) begin
      irq_on_d = 1'b0;
    end
    // restart may also land while the pin is asserted; it then withdraws it
    begin_hold = (restart || (irq_on_q && !irq_on_d && !active))
                 && (cfg_d.interval != 8'h00);
  end

  irqoc_tick u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .clr     (begin_hold),
    .tick    (tick)
  );

  irqoc_holdoff u_holdoff (
    .clk        (clk),
    .reset_n    (reset_n),
    .soft_rst   (soft_rst),
    .tick       (tick),
    .begin_hold (begin_hold),
    .interval   (cfg_d.interval),
    .active     (active)
  );

  // ---------------------------------------------------------------------------
  // pin driver
  // ---------------------------------------------------------------------------
  logic pin_out_d;
  logic pin_oe_d;

  always_comb begin
    if (cfg_q.drv) begin
      pin_oe_d  = 1'b1;
      pin_out_d = cfg_q.pol ? irq_on_d : !irq_on_d;
    end else begin
      // open drain: pull low to assert, release otherwise
      pin_oe_d  = irq_on_d;
      pin_out_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_on_q    <= 1'b0;
      irq_pin_out <= 1'b0;
      irq_pin_oe  <= 1'b0;
    end else begin
      irq_on_q    <= irq_on_d;
      irq_pin_out <= pin_out_d;
      irq_pin_oe  <= pin_oe_d;
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] cfg_word(input irqoc_pkg::irqoc_cfg_s c, input logic act,
                                           input logic comb);
    logic [31:0] w;
    w = 32'h00000000;
    w[irqoc_pkg::CFG_INTERVAL_LSB +: 8] = c.interval;
    w[irqoc_pkg::CFG_ACTIVE_BIT]        = act;
    w[irqoc_pkg::CFG_COMBINED_BIT]      = comb;
    w[irqoc_pkg::CFG_PIN_EN_BIT]        = c.pin_en;
    w[irqoc_pkg::CFG_POL_BIT]           = c.pol;
    w[irqoc_pkg::CFG_DRV_BIT]           = c.drv;
    cfg_word = w;
  endfunction

  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = rdata;
    if (req.rd) begin
      case (req.addr)
        irqoc_pkg::ADDR_IDENT: rdata_d = {DESIGN_CODE, REVISION};
        irqoc_pkg::ADDR_CFG:   rdata_d = cfg_word(cfg_q, active, combined);
        irqoc_pkg::ADDR_FLAGS: rdata_d = flags_q;
        irqoc_pkg::ADDR_MASK:  rdata_d = mask_q;
        default:               rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || soft_rst);

  sequence s_cfg_read;
    req.rd && req.addr == irqoc_pkg::ADDR_CFG;
  endsequence

  sequence s_restart_write;
    wr_cfg && req.wdata[irqoc_pkg::CFG_RESTART_BIT] && req.wdata[31:24] != 8'h00;
  endsequence

  chk_pin_disabled: assert property (!cfg_q.pin_en |=> !irq_on_q)
    else $error("pin asserted while disabled");

  chk_od_low_only: assert property (!cfg_q.drv |=> !irq_pin_out && (irq_pin_oe == irq_on_q))
    else $error("open drain pin drove high");

  // pin was just cleared by system reset, not driven from the old style
  chk_pp_polarity: assert property ($past(reset_n) && $past(cfg_q.drv) && !$past(soft_rst)
      |-> irq_pin_oe && irq_pin_out == (irq_on_q ? $past(cfg_q.pol) : !$past(cfg_q.pol)))
    else $error("push-pull level wrong");

  chk_combined_read: assert property (s_cfg_read
      |=> rdata[irqoc_pkg::CFG_COMBINED_BIT] == $past(|(flags_q & mask_q)))
    else $error("combined bit wrong");

  chk_wake_bypass: assert property (wake_req && cfg_q.pin_en |=> irq_on_q)
    else $error("wake request held off");

  chk_holdoff_gate: assert property (active && !wake_req |=> !irq_on_q)
    else $error("request passed during hold-off");

  chk_zero_cancel: assert property (cfg_q.interval == 8'h00 |-> !active)
    else $error("hold-off running with zero interval");

  chk_restart_run: assert property (s_restart_write |=> active ##1 active)
    else $error("restart did not start interval");

  chk_deassert_hold: assert property (irq_on_q && !irq_on_d && !wake_req && cfg_d.interval != 8'h00
      |=> active)
    else $error("hold-off not started at deassertion");

  chk_flag_set: assert property ((src_event & irqoc_pkg::SRC_IMPL_MASK) != 32'h00000000
      |=> ($past(src_event & irqoc_pkg::SRC_IMPL_MASK) & ~flags_q) == 32'h00000000)
    else $error("event lost");

  chk_flag_clear: assert property (wr_flags && (src_event & req.wdata) == 32'h00000000
      |=> (flags_q & $past(req.wdata)) == 32'h00000000)
    else $error("write one did not clear");

  chk_soft_reset_immune_keep: assert property (@(posedge clk) disable iff (!reset_n)
      soft_rst && !wr_cfg |=> cfg_q.pol == $past(cfg_q.pol) && cfg_q.drv == $past(cfg_q.drv))
    else $error("soft reset changed pin style");

  sequence s_ident_read;
    req.rd && req.addr == irqoc_pkg::ADDR_IDENT;
  endsequence

  sequence s_interval_zero;
    wr_cfg && req.wdata[irqoc_pkg::CFG_INTERVAL_LSB +: 8] == 8'h00;
  endsequence

  chk_ident_fixed: assert property (s_ident_read |=> rdata == {DESIGN_CODE, REVISION})
    else $error("identity word wrong");

  chk_restart_reads_zero: assert property (s_cfg_read |=> !rdata[irqoc_pkg::CFG_RESTART_BIT])
    else $error("restart bit read as one");

  chk_active_read: assert property (s_cfg_read |=> rdata[irqoc_pkg::CFG_ACTIVE_BIT] == $past(active))
    else $error("hold-off status bit wrong");

  chk_zero_stops: assert property (s_interval_zero |=> !active)
    else $error("zero interval left hold-off running");

endmodule // irqoc_top

// [irqoc_host.sv]
`timescale 1ns/1ns
// -----------------------------------------------------------------------------
// host side of the request pin: shared line with pull-up
// -----------------------------------------------------------------------------
module irqoc_host (
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic active_high,
  output logic      irq_req
);
  logic line;

  // released line floats up through the board pull-up
  assign line    = pin_oe ? pin_out : 1'b1;
  assign irq_req = active_high ? (line === 1'b1) : (line === 1'b0);
endmodule // irqoc_host

// [irq_output_control_test.sv]
`timescale 1ns/1ns
module irq_output_control_test;
  logic                  clk        = 1'b0;
  logic                  reset_n    = 1'b0;
  logic                  soft_rst   = 1'b0;
  irqoc_pkg::irqoc_req_s req        = '0;
  logic [31:0]           src_event  = 32'h0;
  logic [31:0]           rdata;
  logic                  irq_pin_out;
  logic                  irq_pin_oe;
  logic                  irq_req;
  logic                  act_high   = 1'b0;
  logic [31:0]           m_flags    = 32'h0;
  logic [31:0]           m_mask     = 32'h0;
  logic [31:0]           r;
  logic [31:0]           v;
  int                    n;
  int                    miscompares = 0;
  int                    n_checks    = 0;

  always #4 clk = ~clk;

  irqoc_top uut (
    .clk(clk), .reset_n(reset_n), .soft_rst(soft_rst), .req(req), .rdata(rdata),
    .src_event(src_event), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe)
  );
  irqoc_host host (.pin_out(irq_pin_out), .pin_oe(irq_pin_oe), .active_high(act_high), .irq_req(irq_req));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
    if (a == irqoc_pkg::ADDR_FLAGS) m_flags = m_flags & ~d;
    if (a == irqoc_pkg::ADDR_MASK) m_mask = d & irqoc_pkg::SRC_IMPL_MASK;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= {1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic ev(input logic [31:0] b);
    @(posedge clk);
    src_event <= b;
    @(posedge clk);
    src_event <= 32'h0;
    m_flags = m_flags | (b & irqoc_pkg::SRC_IMPL_MASK);
  endtask

  // counts falling edges until the host sees the wanted request level
  task automatic wait_pin(input logic want, input int bound, output int cnt);
    cnt = 0;
    @(negedge clk);
    while (irq_req !== want) begin
      @(negedge clk);
      cnt++;
      if (cnt > bound) begin
        miscompares++;
        $display("[ERR] %0t pin wait timed out", $time);
        end_sim();
      end
    end
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    v = $urandom(32'hf22e);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(irqoc_pkg::ADDR_IDENT, r); chk(r, 32'h1D5A0003);
    wr(irqoc_pkg::ADDR_IDENT, 32'hFFFFFFFF);
    rd(irqoc_pkg::ADDR_IDENT, r); chk(r, 32'h1D5A0003);
    rd(irqoc_pkg::ADDR_CFG, r); chk(r, 32'h0);
    rd(8'h60, r); chk(r, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(irqoc_pkg::ADDR_MASK, $urandom);
      rd(irqoc_pkg::ADDR_MASK, r); chk(r, m_mask);
      ev($urandom);
      rd(irqoc_pkg::ADDR_FLAGS, r); chk(r, m_flags);
      rd(irqoc_pkg::ADDR_CFG, r); chk(r[12], |(m_flags & m_mask));
      wr(irqoc_pkg::ADDR_FLAGS, $urandom);
      rd(irqoc_pkg::ADDR_FLAGS, r); chk(r, m_flags);
    end
    wr(irqoc_pkg::ADDR_FLAGS, 32'hFFFFFFFF);
    wr(irqoc_pkg::ADDR_MASK, 32'h00020001);
    ev(32'h1);
    // every enable, polarity and driver combination with a request pending
    for (int i = 0; i < 8; i++) begin
      v = {23'h0, i[2], 3'h0, i[1], 3'h0, i[0]};
      act_high = i[1] & i[0];
      wr(irqoc_pkg::ADDR_CFG, v);
      repeat (2) @(negedge clk);
      chk(irq_req, i[2]);
      chk(irq_pin_oe, i[0] | i[2]);
      rd(irqoc_pkg::ADDR_CFG, r); chk(r, v | 32'h1000);
    end
    wr(irqoc_pkg::ADDR_CFG, 32'h01000111);
    wr(irqoc_pkg::ADDR_FLAGS, 32'h1);
    wait_pin(1'b0, 4, n);
    rd(irqoc_pkg::ADDR_CFG, r); chk(r[13], 1'b1);
    ev(32'h1);
    wait_pin(1'b1, 1400, n); chk(n >= 1230 && n <= 1252, 1'b1);
    wr(irqoc_pkg::ADDR_CFG, 32'h02000111);
    wr(irqoc_pkg::ADDR_FLAGS, 32'h1);
    wait_pin(1'b0, 4, n);
    ev(32'h1);
    wait_pin(1'b1, 2700, n); chk(n >= 2480 && n <= 2502, 1'b1);
    wr(irqoc_pkg::ADDR_FLAGS, 32'h1);
    wait_pin(1'b0, 4, n);
    ev(32'h00020000);
    wait_pin(1'b1, 4, n); chk(n <= 3, 1'b1);
    wr(irqoc_pkg::ADDR_FLAGS, 32'h00020000);
    wait_pin(1'b0, 4, n);
    ev(32'h1);
    repeat (20) @(negedge clk);
    chk(irq_req, 1'b0);
    wr(irqoc_pkg::ADDR_CFG, 32'h00000111);
    wait_pin(1'b1, 4, n); chk(n <= 3, 1'b1);
    rd(irqoc_pkg::ADDR_CFG, r); chk(r[13], 1'b0);
    wr(irqoc_pkg::ADDR_CFG, 32'h01000111);
    wr(irqoc_pkg::ADDR_CFG, 32'h01004111);
    wait_pin(1'b0, 4, n);
    rd(irqoc_pkg::ADDR_CFG, r); chk(r[14:12], 3'b011);
    wait_pin(1'b1, 1400, n); chk(n >= 1230 && n <= 1252, 1'b1);
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    rd(irqoc_pkg::ADDR_CFG, r); chk(r, 32'h00000011);
    chk(irq_req, 1'b0);
    rd(irqoc_pkg::ADDR_FLAGS, r); chk(r, 32'h0);
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    rd(irqoc_pkg::ADDR_CFG, r); chk(r, 32'h0);
    chk(irq_pin_oe, 1'b0);
    end_sim();
  end
endmodule // irq_output_control_test
